// file: verilog/eep_slave.sv
// Two-wire serial EEPROM slave: address decode, acknowledge, page buffer,
// reads and the internal address counter.
// Assumes an open-drain bus resolved outside; scl also clocks a bit catcher.
//
// How it works
// R1: Received write bytes reach the array only after a stop.
// R2: Master sends the slave address first after every start.
// R3: Upper four address bits must equal the device type code.
// R4: Small densities compare three select bits with three select pins.
// R5: Address bit zero picks direction: 0 write or dummy write, 1 read.
// R6: Largest density compares two select bits with the upper two pins.
// R7: Largest density uses the next address bit as array address bit eight.
// R8: Write inhibit high blocks every write; low allows all.
// R9: Transmitter releases data after eight bits; receiver acks low on ninth.
// R10: Device acks a matching slave address, word address and write data.
// R11: During reads a low ack without stop sends the next byte.
// R12: Missing ack stops driving, read ends at stop, back to standby.
// R13: Byte write stores one byte at word address, committed at stop.
// R14: Small density page write fixes bits six to three, eight bytes.
// R15: Middle density page write fixes bits seven to three, eight bytes.
// R16: Large density page write fixes bits eight to four, sixteen bytes.
// R17: After any read the counter holds last read address plus one.
// R18: After a write the counter stays on the last written address.
// R19: Current read with no ack then stop gives exactly one byte.
// R20: Master ends reads with high ack then a stop.
// R21: Random read returns data from the dummy write word address.
// R22: Master keeps both lines high while power ramps.
// R23: Start is data falling with clock high; stop is data rising.
// R24: Mismatched slave address: no ack, ignore bytes until next start.
// R25: Excess page write bytes wrap inside the same page.
`timescale 1ns/1ns
`include "eep_regs.svh"

module eep_slave
    import eep_pkg::*;
#(
    parameter logic [1:0] DENSITY   = `EEP_DEN_LARGE,
    // Arbitrary value, set per product
    parameter logic [3:0] TYPE_CODE = `EEP_TYPE_DEFAULT
)(
    // System
    input  wire logic clock,
    input  wire logic rstn,
    // Bus link
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Strap pins
    input  wire logic device_select_pin_low,
    input  wire logic device_select_pin_mid,
    input  wire logic device_select_pin_high,
    input  wire logic write_inhibit,
    // Status
    output logic      prog_busy
);

    localparam bit LARGE = (DENSITY == `EEP_DEN_LARGE);
    localparam int AW    = LARGE ? `EEP_AW_LARGE :
                           (DENSITY == `EEP_DEN_MID) ? `EEP_AW_MID : `EEP_AW_SMALL;
    localparam int PG    = LARGE ? `EEP_PG_LARGE : `EEP_PG_SMALL;
    localparam int NPIN  = `EEP_NPIN;

    // =====================================
    // Pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_s;

    assign pin_raw = {write_inhibit, device_select_pin_high, device_select_pin_mid,
                      device_select_pin_low, sda_in, scl};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    pin_meta[gi] <= `EEP_PIN_IDLE;
                    pin_s[gi]    <= `EEP_PIN_IDLE;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_s[gi]    <= pin_meta[gi];
                end
            end
        end
    endgenerate

    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [2:0] sel_s;

    assign scl_s = pin_s[`EEP_PIN_SCL];
    assign sda_s = pin_s[`EEP_PIN_SDA];
    assign wp_s  = pin_s[`EEP_PIN_WP];
    assign sel_s = pin_s[`EEP_PIN_SEL_HI:`EEP_PIN_SEL_LO];

    // =====================================
    // Link domain bit catcher
    // Read only after the synced clock shows a rising edge, so it is stable.
    logic cap_bit;

    always_ff @(posedge scl) begin
        cap_bit <= sda_in;
    end

    // =====================================
    // Bus conditions
    logic scl_d;
    logic sda_d;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            scl_d <= `EEP_PIN_IDLE;
            sda_d <= `EEP_PIN_IDLE;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic start_evt;
    logic stop_evt;
    logic rise_evt;
    logic fall_evt;

    assign start_evt = scl_s && scl_d && sda_d && !sda_s; // R23
    assign stop_evt  = scl_s && scl_d && !sda_d && sda_s; // R23
    assign rise_evt  = scl_s && !scl_d;
    assign fall_evt  = !scl_s && scl_d;

    // =====================================
    // Byte framing
    eep_state_e state;
    logic [3:0] cnt;
    logic [7:0] rx;
    logic [7:0] byte_in;
    logic       byte_evt;
    logic       ack_evt;

    assign byte_in  = {rx[6:0], cap_bit};
    assign byte_evt = rise_evt && (cnt == `EEP_LAST_DATA) && (state != ST_PROG);
    assign ack_evt  = rise_evt && (cnt == `EEP_ACK_SLOT) && (state != ST_PROG);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cnt <= `EEP_CNT_ZERO;
        end else if (start_evt || stop_evt) begin
            cnt <= `EEP_CNT_ZERO;
        end else if (rise_evt) begin
            cnt <= (cnt == `EEP_ACK_SLOT) ? `EEP_CNT_ZERO : cnt + `EEP_CNT_ONE; // R9
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rx <= '0;
        end else if (rise_evt && cnt != `EEP_ACK_SLOT) begin
            rx <= byte_in;
        end
    end

    // =====================================
    // Slave address decode
    function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
        logic ok;
        ok = (b[`EEP_TYPE_HI:`EEP_TYPE_LO] == TYPE_CODE); // R3
        if (LARGE) begin
            ok = ok && (b[`EEP_SEL_HI:`EEP_SEL2_LO] == sel[2:1]); // R6
        end else begin
            ok = ok && (b[`EEP_SEL_HI:`EEP_SEL_LO] == sel); // R4
        end
        return ok;
    endfunction

    logic addr_hit;
    logic is_read;

    assign addr_hit = dev_match(byte_in, sel_s);
    assign is_read  = byte_in[`EEP_RW_BIT]; // R5

    // =====================================
    // Command sequencer
    logic [PG-1:0] pidx;
    logic [(1<<PG)-1:0] pvalid;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else if (state == ST_PROG) begin
            if (pidx == '1) begin
                state <= ST_IDLE;
            end
        end else if (start_evt) begin
            state <= ST_DEVADDR; // R2 R23
        end else if (stop_evt) begin
            // Commit only a terminated write with data, and only when allowed
            if (state == ST_WRDATA && (|pvalid) && !wp_s) begin
                state <= ST_PROG; // R1 R8 R13
            end else begin
                state <= ST_IDLE; // R12 R19
            end
        end else if (byte_evt) begin
            case (state)
                ST_DEVADDR: begin
                    if (!addr_hit) begin
                        state <= ST_IGNORE; // R24
                    end else if (is_read) begin
                        state <= ST_RDDATA; // R5
                    end else begin
                        state <= ST_WORDADDR; // R5
                    end
                end
                ST_WORDADDR: state <= ST_WRDATA;
                default:     state <= state;
            endcase
        end else if (ack_evt && state == ST_RDDATA && cap_bit) begin
            state <= ST_IGNORE; // R12 R20
        end
    end

    // =====================================
    // Acknowledge decision
    logic ack_pend;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ack_pend <= 1'b0;
        end else if (start_evt || stop_evt) begin
            ack_pend <= 1'b0;
        end else if (byte_evt) begin
            case (state)
                ST_DEVADDR:  ack_pend <= addr_hit; // R10 R24
                ST_WORDADDR: ack_pend <= 1'b1;     // R10
                ST_WRDATA:   ack_pend <= 1'b1;     // R10
                default:     ack_pend <= 1'b0;
            endcase
        end
    end

    // =====================================
    // Address counter and page pointer
    logic          ps_bit;
    logic [8:0]    waddr9;
    logic [AW-1:0] waddr_full;
    logic [AW-1:0] cur_addr;
    logic [AW-1:0] wbase;
    logic [PG-1:0] wptr;

    assign waddr9     = {ps_bit, byte_in};
    assign waddr_full = waddr9[AW-1:0];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ps_bit   <= 1'b0;
            cur_addr <= '0;
            wbase    <= '0;
            wptr     <= '0;
        end else if (byte_evt) begin
            case (state)
                ST_DEVADDR: begin
                    if (addr_hit) begin
                        ps_bit <= LARGE && byte_in[`EEP_HALF_BIT]; // R7
                    end
                end
                ST_WORDADDR: begin
                    cur_addr <= waddr_full; // R7 R21
                    wbase    <= waddr_full;
                    wptr     <= waddr_full[PG-1:0];
                end
                ST_WRDATA: begin
                    cur_addr <= {wbase[AW-1:PG], wptr}; // R18
                    wptr     <= wptr + 1'b1; // R14 R15 R16 R25
                end
                ST_RDDATA: cur_addr <= cur_addr + 1'b1; // R17
                default:   cur_addr <= cur_addr;
            endcase
        end
    end

    // =====================================
    // Page buffer
    logic [7:0] pbuf [0:(1<<PG)-1];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pvalid <= '0;
        end else if (start_evt) begin
            // An unterminated write is dropped by a new start
            pvalid <= '0;
        end else if (byte_evt && state == ST_WORDADDR) begin
            pvalid <= '0;
        end else if (byte_evt && state == ST_WRDATA) begin
            pbuf[wptr]   <= byte_in; // R13 R25
            pvalid[wptr] <= 1'b1;
        end else if (state == ST_PROG && pidx == '1) begin
            pvalid <= '0;
        end
    end

    // =====================================
    // Array and programming walk
    logic [7:0] mem [0:(1<<AW)-1];
    logic       mem_we;

    assign mem_we = (state == ST_PROG) && pvalid[pidx];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pidx <= '0;
        end else if (state == ST_PROG) begin
            pidx <= pidx + 1'b1;
        end else begin
            pidx <= '0;
        end
    end

    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[{wbase[AW-1:PG], pidx}] <= pbuf[pidx]; // R1 R13
        end
    end

    // =====================================
    // Read shifter
    logic [7:0] tx;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx <= '0;
        end else if (byte_evt && state == ST_DEVADDR && addr_hit && is_read) begin
            tx <= mem[cur_addr]; // R21
        end else if (ack_evt && state == ST_RDDATA && !cap_bit) begin
            tx <= mem[cur_addr]; // R11
        end else if (fall_evt && state == ST_RDDATA && cnt != `EEP_ACK_SLOT) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    // =====================================
    // Data line driver
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sda_oe <= 1'b0;
        end else if (start_evt || stop_evt || state == ST_PROG) begin
            sda_oe <= 1'b0;
        end else if (fall_evt) begin
            if (cnt == `EEP_ACK_SLOT) begin
                sda_oe <= ack_pend; // R9 R10 R24
            end else if (state == ST_RDDATA) begin
                sda_oe <= !tx[7]; // R11
            end else begin
                sda_oe <= 1'b0; // R12
            end
        end
    end

    always_ff @(posedge clock) begin
        sda_out <= `EEP_SDA_LOW;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            prog_busy <= 1'b0;
        end else begin
            prog_busy <= (state == ST_PROG);
        end
    end

    // =====================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_stop_in_write;
        state == ST_WRDATA && stop_evt && (|pvalid);
    endsequence

    sequence s_ack_slot;
        fall_evt && cnt == `EEP_ACK_SLOT && ack_pend && !start_evt && !stop_evt;
    endsequence

    a_commit_on_stop: assert property ( // R13
        s_stop_in_write ##0 !wp_s |=> state == ST_PROG)
        else $error("write not committed at stop");

    a_prog_after_stop: assert property ( // R1
        $rose(state == ST_PROG) |-> $past(stop_evt))
        else $error("programming began without a stop");

    a_inhibit_blocks: assert property ( // R8
        s_stop_in_write ##0 wp_s |=> state == ST_IDLE ##1 !mem_we)
        else $error("write went ahead while inhibited");

    a_type_reject: assert property ( // R3
        byte_evt && state == ST_DEVADDR
        && byte_in[`EEP_TYPE_HI:`EEP_TYPE_LO] != TYPE_CODE && !stop_evt
        |=> state == ST_IGNORE)
        else $error("foreign type code accepted");

    a_ack_drive: assert property ( // R10
        s_ack_slot |=> sda_oe)
        else $error("acknowledge not driven");

    a_ignore_quiet: assert property ( // R24
        state == ST_IGNORE |-> !sda_oe)
        else $error("data line driven while ignoring");

    a_word_load: assert property ( // R21
        byte_evt && state == ST_WORDADDR && !stop_evt
        |=> cur_addr == $past(waddr_full))
        else $error("word address not loaded");

    a_read_step: assert property ( // R17
        byte_evt && state == ST_RDDATA |=> cur_addr == $past(cur_addr) + 1'b1)
        else $error("read counter did not step");

    a_nack_release: assert property ( // R12
        ack_evt && state == ST_RDDATA && cap_bit && !stop_evt && !start_evt
        |=> state == ST_IGNORE ##1 !sda_oe)
        else $error("read kept going after no acknowledge");

    a_page_fixed: assert property ( // R14
        byte_evt && state == ST_WRDATA
        |=> cur_addr[AW-1:PG] == wbase[AW-1:PG] && wptr == $past(wptr) + 1'b1)
        else $error("page write left its page");

    a_start_frames: assert property ( // R23
        start_evt && state != ST_PROG |=> state == ST_DEVADDR && cnt == `EEP_CNT_ZERO)
        else $error("start did not open an address byte");

endmodule // eep_slave

// file: verilog/eep_regs.svh
// Constants for the two-wire serial EEPROM slave.
// Assumes inclusion by bare name from the design files.
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH

// =====================================
// Densities and array shape
`define EEP_DEN_SMALL      2'h0
`define EEP_DEN_MID        2'h1
`define EEP_DEN_LARGE      2'h2
`define EEP_AW_SMALL       7
`define EEP_AW_MID         8
`define EEP_AW_LARGE       9
`define EEP_PG_SMALL       3
`define EEP_PG_LARGE       4

// =====================================
// Slave address byte fields
`define EEP_TYPE_HI        7
`define EEP_TYPE_LO        4
`define EEP_SEL_HI         3
`define EEP_SEL_LO         1
`define EEP_SEL2_LO        2
`define EEP_HALF_BIT       1
`define EEP_RW_BIT         0
`define EEP_TYPE_DEFAULT   4'h5

// =====================================
// Bit slot counter
`define EEP_CNT_ZERO       4'h0
`define EEP_CNT_ONE        4'h1
`define EEP_LAST_DATA      4'h7
`define EEP_ACK_SLOT       4'h8

// =====================================
// Pin synchroniser lanes and reset levels
`define EEP_NPIN           6
`define EEP_PIN_SCL        0
`define EEP_PIN_SDA        1
`define EEP_PIN_SEL_LO     2
`define EEP_PIN_SEL_HI     4
`define EEP_PIN_WP         5
`define EEP_PIN_IDLE       1'h1
`define EEP_SDA_LOW        1'h0

`endif

// file: verilog/eep_pkg.sv
// Types for the two-wire serial EEPROM slave.
// Assumes nothing of its surroundings.
package eep_pkg;

    // =====================================
    // Command sequencer states
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_DEVADDR  = 7'h02,
        ST_WORDADDR = 7'h04,
        ST_WRDATA   = 7'h08,
        ST_RDDATA   = 7'h10,
        ST_IGNORE   = 7'h20,
        ST_PROG     = 7'h40
    } eep_state_e;

endpackage

// file: tb/eep_master.sv
// Two-wire bus master model for the EEPROM slave bench.
// Assumes the bench resolves sda from both open-drain enables.
`timescale 1ns/1ns

module eep_master (
    // Bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    logic tick;

    // =====================================
    // Link tick, 30 ns, free phase to clock
    initial begin
        tick = 1'h0;
        #7;
        forever #15 tick = ~tick;
    end

    // Both lines idle high from power-up
    initial begin
        scl    = 1'h1;
        sda_oe = 1'h0;
    end

    task automatic ph(input int n);
        repeat (n) @(posedge tick);
        #1;
    endtask

    // =====================================
    // Frame edges, also repeated start
    task automatic start();
        sda_oe = 1'h0;
        ph(2);
        scl = 1'h1;
        ph(2);
        sda_oe = 1'h1;
        ph(2);
        scl = 1'h0;
        ph(2);
    endtask

    task automatic stop();
        sda_oe = 1'h1;
        ph(2);
        scl = 1'h1;
        ph(2);
        sda_oe = 1'h0;
        ph(2);
    endtask

    // =====================================
    // One slot: drive, clock high, sample, long hold
    task automatic bit_slot(input logic b, output logic s);
        sda_oe = ~b;
        ph(2);
        scl = 1'h1;
        ph(2);
        s = sda;
        scl = 1'h0;
        ph(2);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] b, input logic ack,
                        output logic [7:0] d, output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], d[i]);
        end
        bit_slot(ack, ack_seen);
    endtask
endmodule // eep_master

// file: tb/eep_slave_tb.sv
// Self-checking bench for the EEPROM slave, largest density.
// Assumes the master model in eep_master.sv and a pull-up on sda.
`timescale 1ns/1ns

module eep_slave_tb;
    localparam logic [3:0] TCODE = 4'h6; // Arbitrary value
    logic        clock, rstn, scl, sda, m_oe, sda_out, sda_oe, prog_busy;
    logic        sel_low, sel_mid, sel_high, write_inhibit;
    logic [31:0] lfsr_state;
    int          failures, compares, ctr;
    int          mem [512];

    // Open drain with pull-up
    assign sda = ~(m_oe | (sda_oe & ~sda_out));

    eep_master eep_master_i (.sda(sda), .scl(scl), .sda_oe(m_oe));

    eep_slave #(.DENSITY(2'h2), .TYPE_CODE(TCODE)) eep_slave_i (
        .clock(clock), .rstn(rstn), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .device_select_pin_low(sel_low), .device_select_pin_mid(sel_mid),
        .device_select_pin_high(sel_high), .write_inhibit(write_inhibit),
        .prog_busy(prog_busy));

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    initial begin
        #600000;
        failures++;
        close_out();
    end

    // =====================================
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr_state = {lfsr_state[30:0],
                      lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state[7:0];
    endfunction

    function automatic logic [7:0] dev(input logic [3:0] t, input logic h, input logic rw);
        return {t, sel_high, sel_mid, h, rw};
    endfunction

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Byte to the slave; exp_ack high means a low acknowledge is due
    task automatic xb(input logic [7:0] b, input logic exp_ack);
        logic [7:0] d;
        logic       a;
        eep_master_i.xfer(b, 1'h1, d, a);
        check("ack", {8'h00, a}, {8'h00, ~exp_ack});
    endtask

    // =====================================
    // Operations with the reference model
    task automatic wr(input logic h, input logic [7:0] wa, input int n, input logic drop);
        logic [7:0] b;
        logic       seen;
        int         a;
        int         k;
        eep_master_i.start();
        xb(dev(TCODE, h, 1'h0), 1'h1);
        xb(wa, 1'h1);
        ctr = {h, wa};
        for (int i = 0; i < n; i++) begin
            b = rnd();
            xb(b, 1'h1);
            a = {h, wa[7:4], 4'(wa[3:0] + i)};
            if (!write_inhibit && !drop) mem[a] = b;
            ctr = a;
        end
        if (drop) eep_master_i.start();
        eep_master_i.stop();
        seen = 1'h0;
        repeat (12) begin
            @(posedge clock);
            #1;
            seen = seen | prog_busy;
        end
        if (drop) check("prog_busy", {8'h00, seen}, 9'h000);
        if (!drop && write_inhibit) check("prog_busy", {8'h00, seen}, 9'h000);
        if (!drop && n > 0 && !write_inhibit) check("prog_busy", {8'h00, seen}, 9'h001);
        k = 0;
        while (prog_busy !== 1'h0 && k < 200) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k >= 200) failures++;
    endtask

    task automatic rd(input logic ra, input logic h, input logic [7:0] wa, input int n);
        logic [7:0] d;
        logic       a;
        if (ra) begin
            eep_master_i.start();
            xb(dev(TCODE, h, 1'h0), 1'h1);
            xb(wa, 1'h1);
            ctr = {h, wa};
        end
        eep_master_i.start();
        xb(dev(TCODE, h, 1'h1), 1'h1);
        for (int i = 0; i < n; i++) begin
            eep_master_i.xfer(8'hFF, 1'(i == n - 1), d, a);
            if (mem[ctr] >= 0) check("rdata", {1'h0, d}, 9'(mem[ctr]));
            ctr = (ctr + 1) % 512;
        end
        check("release", {8'h00, sda_oe}, 9'h000);
        check("sda_out", {8'h00, sda_out}, 9'h000);
        eep_master_i.stop();
    endtask

    task automatic bad(input logic [7:0] a);
        eep_master_i.start();
        xb(a, 1'h0);
        xb(8'h00, 1'h0);
        eep_master_i.stop();
    endtask

    task automatic set_wi(input logic v);
        @(posedge clock);
        #1;
        write_inhibit = v;
    endtask

    // =====================================
    // Main sequence
    initial begin
        rstn          = 1'h0;
        write_inhibit = 1'h0;
        failures      = 0;
        compares      = 0;
        lfsr_state    = 32'h0DAD498E;
        {sel_high, sel_mid, sel_low} = lfsr_state[2:0];
        for (int i = 0; i < 512; i++) mem[i] = -1;
        repeat (4) @(posedge clock);
        #1;
        rstn = 1'h1;
        repeat (3) @(posedge clock);
        #1;
        wr(1'h1, 8'h22, 2, 1'h0);
        wr(1'h0, 8'h23, 1, 1'h0);
        rd(1'h0, 1'h0, 8'h00, 1);
        rd(1'h1, 1'h1, 8'h23, 1);
        @(posedge clock);
        #1;
        sel_low = ~sel_low;
        wr(1'h0, 8'h40, 16, 1'h0);
        wr(1'h0, 8'h50, 16, 1'h0);
        wr(1'h0, 8'h85, 18, 1'h0);
        rd(1'h1, 1'h0, 8'h48, 10);
        rd(1'h0, 1'h0, 8'h00, 1);
        rd(1'h1, 1'h0, 8'h80, 16);
        set_wi(1'h1);
        wr(1'h1, 8'h23, 1, 1'h0);
        set_wi(1'h0);
        rd(1'h1, 1'h1, 8'h23, 1);
        wr(1'h0, 8'h41, 2, 1'h1);
        rd(1'h1, 1'h0, 8'h41, 2);
        bad(dev(TCODE ^ 4'h1, 1'h0, 1'h0));
        bad({TCODE, ~sel_high, sel_mid, 2'h0});
        rd(1'h1, 1'h1, 8'h22, 2);
        close_out();
    end
endmodule // eep_slave_tb
